// >>> rtl/ufh_pkg.sv
/*
 * Constants, types and timing figures shared by the full-speed hub/function logic.
 * Assumes a 40 MHz clock and a protocol engine outside that decodes tokens and requests.
 */
package ufh_pkg;
    localparam int CLK_KHZ = 40000;
    localparam int SUSPEND_IDLE_MS = 3;
    localparam int SUSPEND_IDLE_CYC = SUSPEND_IDLE_MS * CLK_KHZ;
    localparam int RESUME_DRIVE_MS = 10;
    localparam int RESUME_DRIVE_CYC = RESUME_DRIVE_MS * CLK_KHZ;
    localparam int TMR_W = 19;

    localparam logic [1:0] TGT_HUB = 2'h0;
    localparam logic [1:0] TGT_KBD = 2'h1;
    localparam logic [1:0] TGT_MOUSE = 2'h2;
    localparam logic [1:0] TGT_BT = 2'h3;

    localparam int CFG_HUB_BIT = 0;
    localparam int CFG_KBD_BIT = 1;
    localparam int CFG_MOUSE_BIT = 2;
    localparam int CFG_BT_BIT = 3;
    localparam int CFG_W = 4;

    localparam int PORT_KBD = 0;
    localparam int PORT_MOUSE = 1;
    localparam int PORT_BT = 2;
    localparam int PORTS = 3;

    localparam logic [7:0] EP_CTRL = 8'h00;
    localparam logic [7:0] EP_EVT_IN = 8'h81;
    localparam logic [7:0] EP_ACL_IN = 8'h82;
    localparam logic [7:0] EP_ACL_OUT = 8'h02;
    localparam logic [7:0] EP_SCO_IN = 8'h83;
    localparam logic [7:0] EP_SCO_OUT = 8'h03;
    localparam logic [7:0] EP_DBG_IN = 8'h84;
    localparam logic [7:0] EP_DBG_OUT = 8'h04;
    localparam logic [2:0] ALT_NONE = 3'h0;

    localparam int DESC_OFS_W = 6;
    localparam int DESC_AW = 8;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_RUN = 2'b01,
        ST_SUSP = 2'b10,
        ST_WAKE = 2'b11
    } ufh_state_t;
endpackage : ufh_pkg

// >>> rtl/ufh_desc_mem.sv
/*
 * Descriptor store: one 64-byte region per target, filled from nonvolatile storage.
 * Assumes the loader writes whole descriptors before boot completes.
 */
`timescale 1ns/1ps
`default_nettype none
module ufh_desc_mem
    import ufh_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [DESC_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [DESC_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:(1<<DESC_AW)-1];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rd_data <= DATA_ZERO;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : ufh_desc_mem
`default_nettype wire

// >>> rtl/ufh_core.sv
/*
 * Device-side configuration, request gating and power state of the full-speed compound function.
 * Assumes an outside protocol engine that decodes requests and reports line activity.
 */
`timescale 1ns/1ps
`default_nettype none
module ufh_core
    import ufh_pkg::*;
#(
    parameter int SUSPEND_CYC = SUSPEND_IDLE_CYC,
    parameter int RESUME_CYC = RESUME_DRIVE_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic cfg_load,
    input wire logic [CFG_W-1:0] cfg_record,
    input wire logic desc_wr,
    input wire logic [DESC_AW-1:0] desc_wr_addr,
    input wire logic [7:0] desc_wr_data,
    input wire logic desc_done,
    input wire logic bus_activity,
    input wire logic req_valid,
    input wire logic [1:0] req_target,
    input wire logic [7:0] req_ep,
    input wire logic [2:0] req_alt,
    input wire logic [DESC_OFS_W-1:0] req_desc_ofs,
    input wire logic rwake_en,
    input wire logic wake_req,
    input wire logic [PORTS-1:0] port_susp_set,
    input wire logic [PORTS-1:0] port_susp_clr,
    output logic attach,
    output logic hub_mode,
    output logic hid_emulation_mode,
    output logic [PORTS-1:0] port_connected,
    output logic [PORTS-1:0] port_suspended,
    output logic usb_transport,
    output logic suspended,
    output logic resume_drive,
    output logic resp_valid,
    output logic resp_ack,
    output logic resp_stall,
    output logic [7:0] resp_data
);
    localparam logic [TMR_W-1:0] SUSP_LAST = TMR_W'(SUSPEND_CYC - 1);
    localparam logic [TMR_W-1:0] WAKE_LAST = TMR_W'(RESUME_CYC - 1);
    localparam logic [TMR_W-1:0] TMR_ZERO = '0;
    localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

    ufh_state_t state, next_state;
    logic cfg_seen, next_cfg_seen;
    logic kbd_en, next_kbd_en;
    logic mouse_en, next_mouse_en;
    logic bt_en, next_bt_en;
    logic next_hub_mode, next_hid_mode, next_attach, next_usb_transport;
    logic next_suspended, next_resume_drive;
    logic [PORTS-1:0] next_port_connected, next_port_suspended;
    logic [TMR_W-1:0] timer, next_timer;
    logic stage_valid, next_stage_valid;
    logic stage_ok, next_stage_ok;
    logic next_resp_valid, next_resp_ack, next_resp_stall;
    logic [7:0] next_resp_data;
    logic [7:0] mem_rd_data;
    logic tgt_present, tgt_asleep, tgt_is_bt, ep_ok;

    // Configuration, attach and power state.
    always_comb begin
        next_state = state;
        next_cfg_seen = cfg_seen;
        next_kbd_en = kbd_en;
        next_mouse_en = mouse_en;
        next_bt_en = bt_en;
        next_hub_mode = hub_mode;
        next_timer = timer;
        next_usb_transport = usb_transport;
        if (state == ST_BOOT && cfg_load && !cfg_seen) begin
            next_cfg_seen = 1'b1;
            next_kbd_en = cfg_record[CFG_KBD_BIT];
            next_mouse_en = cfg_record[CFG_MOUSE_BIT];
            // Either emulated HID device drags the hub in.
            next_hub_mode = cfg_record[CFG_HUB_BIT] | cfg_record[CFG_KBD_BIT]
                | cfg_record[CFG_MOUSE_BIT];
            // Without HID devices the Bluetooth core must exist, alone or on the hub.
            next_bt_en = cfg_record[CFG_BT_BIT]
                | ~(cfg_record[CFG_KBD_BIT] | cfg_record[CFG_MOUSE_BIT]);
        end
        if (attach && bus_activity) begin
            next_usb_transport = 1'b1;
        end
        case (state)
            ST_BOOT: begin
                if (cfg_seen && desc_done) begin
                    next_state = ST_RUN;
                    next_timer = TMR_ZERO;
                end
            end
            ST_RUN: begin
                if (bus_activity) begin
                    next_timer = TMR_ZERO;
                end else if (timer == SUSP_LAST) begin
                    next_state = ST_SUSP;
                    next_timer = TMR_ZERO;
                end else begin
                    next_timer = timer + TMR_ONE;
                end
            end
            ST_SUSP: begin
                if (bus_activity) begin
                    next_state = ST_RUN;
                end else if (wake_req && rwake_en) begin
                    next_state = ST_WAKE;
                    next_timer = TMR_ZERO;
                end
            end
            default: begin
                if (timer == WAKE_LAST) begin
                    next_state = ST_RUN;
                    next_timer = TMR_ZERO;
                end else begin
                    next_timer = timer + TMR_ONE;
                end
            end
        endcase
        // Full-speed pull-up only; no high-speed chirp is ever attempted.
        next_attach = (next_state != ST_BOOT);
        next_suspended = (next_state == ST_SUSP);
        next_resume_drive = (next_state == ST_WAKE);
        next_hid_mode = next_kbd_en | next_mouse_en;
        // Port map: 1 keyboard core, 2 mouse core, 3 Bluetooth core.
        next_port_connected = '0;
        if (next_hub_mode && next_attach) begin
            next_port_connected[PORT_KBD] = next_kbd_en;
            next_port_connected[PORT_MOUSE] = next_mouse_en;
            next_port_connected[PORT_BT] = next_bt_en;
        end
        // Selective suspend per port; set wins over clear.
        next_port_suspended = ((port_suspended & ~port_susp_clr) | port_susp_set)
            & next_port_connected;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= ST_BOOT;
            cfg_seen <= 1'b0;
            kbd_en <= 1'b0;
            mouse_en <= 1'b0;
            bt_en <= 1'b0;
            hub_mode <= 1'b0;
            hid_emulation_mode <= 1'b0;
            timer <= TMR_ZERO;
            usb_transport <= 1'b0;
            attach <= 1'b0;
            suspended <= 1'b0;
            resume_drive <= 1'b0;
            port_connected <= '0;
            port_suspended <= '0;
        end else begin
            state <= next_state;
            cfg_seen <= next_cfg_seen;
            kbd_en <= next_kbd_en;
            mouse_en <= next_mouse_en;
            bt_en <= next_bt_en;
            hub_mode <= next_hub_mode;
            hid_emulation_mode <= next_hid_mode;
            timer <= next_timer;
            usb_transport <= next_usb_transport;
            attach <= next_attach;
            suspended <= next_suspended;
            resume_drive <= next_resume_drive;
            port_connected <= next_port_connected;
            port_suspended <= next_port_suspended;
        end
    end

    ufh_desc_mem u_desc_mem (
        .clock(clock),
        .rstn(rstn),
        .wr_en(desc_wr),
        .wr_addr(desc_wr_addr),
        .wr_data(desc_wr_data),
        .rd_addr({req_target, req_desc_ofs}),
        .rd_data(mem_rd_data)
    );

    // Request gating and answer pipeline.
    always_comb begin
        tgt_present = 1'b0;
        tgt_asleep = 1'b0;
        tgt_is_bt = 1'b0;
        if (!hub_mode) begin
            tgt_present = (req_target == TGT_HUB);
            tgt_is_bt = 1'b1;
        end else if (req_target == TGT_HUB) begin
            tgt_present = 1'b1;
        end else if (req_target == TGT_KBD) begin
            tgt_present = port_connected[PORT_KBD];
            tgt_asleep = port_suspended[PORT_KBD];
        end else if (req_target == TGT_MOUSE) begin
            tgt_present = port_connected[PORT_MOUSE];
            tgt_asleep = port_suspended[PORT_MOUSE];
        end else begin
            tgt_present = port_connected[PORT_BT];
            tgt_asleep = port_suspended[PORT_BT];
            tgt_is_bt = 1'b1;
        end
        if (tgt_is_bt) begin
            ep_ok = (req_ep == EP_CTRL) || (req_ep == EP_EVT_IN)
                || (req_ep == EP_ACL_IN) || (req_ep == EP_ACL_OUT)
                || (req_ep == EP_DBG_IN) || (req_ep == EP_DBG_OUT)
                || (((req_ep == EP_SCO_IN) || (req_ep == EP_SCO_OUT))
                    && (req_alt != ALT_NONE));
        end else begin
            // Hub and emulated HID cores expose only control and interrupt IN.
            ep_ok = (req_ep == EP_CTRL) || (req_ep == EP_EVT_IN);
        end
        // Only present, awake targets are answered, hub and functions alike.
        next_stage_valid = req_valid && (state == ST_RUN) && tgt_present && !tgt_asleep;
        next_stage_ok = ep_ok;
        next_resp_valid = stage_valid;
        next_resp_ack = stage_valid && stage_ok;
        next_resp_stall = stage_valid && !stage_ok;
        next_resp_data = (stage_valid && stage_ok) ? mem_rd_data : DATA_ZERO;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            stage_valid <= 1'b0;
            stage_ok <= 1'b0;
            resp_valid <= 1'b0;
            resp_ack <= 1'b0;
            resp_stall <= 1'b0;
            resp_data <= DATA_ZERO;
        end else begin
            stage_valid <= next_stage_valid;
            stage_ok <= next_stage_ok;
            resp_valid <= next_resp_valid;
            resp_ack <= next_resp_ack;
            resp_stall <= next_resp_stall;
            resp_data <= next_resp_data;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    hid_forces_hub_a: assert property ((state == ST_BOOT && cfg_load && !cfg_seen
        && (cfg_record[CFG_KBD_BIT] || cfg_record[CFG_MOUSE_BIT])) |=> hub_mode)
        else $error("HID device enabled without hub.");
    single_no_ports_a: assert property (!hub_mode |-> port_connected == '0)
        else $error("Port reported connected in single mode.");
    disabled_silent_a: assert property ((req_valid && hub_mode && req_target == TGT_KBD
        && !port_connected[PORT_KBD]) |-> ##2 !resp_valid)
        else $error("Disabled keyboard answered.");
    bt_port_cfg_a: assert property ((hub_mode && attach) |-> port_connected[PORT_BT] == bt_en)
        else $error("Bluetooth port presence differs from configuration.");
    iso_needs_alt_a: assert property ((req_valid && state == ST_RUN && !hub_mode
        && req_target == TGT_HUB && req_ep == EP_SCO_IN && req_alt == ALT_NONE)
        |-> ##2 (resp_valid && resp_stall))
        else $error("Isochronous endpoint answered without alternate setting.");
    event_ep_ack_a: assert property ((req_valid && state == ST_RUN && !hub_mode
        && req_target == TGT_HUB && req_ep == EP_EVT_IN) |-> ##2 (resp_valid && resp_ack))
        else $error("Event endpoint not acknowledged.");
    debug_ep_ack_a: assert property ((req_valid && state == ST_RUN && !hub_mode
        && req_target == TGT_HUB && req_ep == EP_DBG_OUT) |-> ##2 resp_ack)
        else $error("Debug endpoint not acknowledged.");
    hid_ep_limit_a: assert property ((req_valid && state == ST_RUN && hub_mode
        && req_target == TGT_MOUSE && port_connected[PORT_MOUSE] && !port_suspended[PORT_MOUSE]
        && req_ep == EP_ACL_IN) |-> ##2 resp_stall)
        else $error("Emulated mouse exposed a Bluetooth endpoint.");
    usb_select_a: assert property ((attach && bus_activity) |=> usb_transport)
        else $error("Transport not selected on bus activity.");
    attach_after_load_a: assert property ($rose(attach) |-> $past(cfg_seen && desc_done))
        else $error("Attached before descriptors were loaded.");
    wake_cause_a: assert property ($rose(resume_drive)
        |-> $past(suspended && wake_req && rwake_en && !bus_activity))
        else $error("Remote wakeup without enable or suspend.");
endmodule : ufh_core
`default_nettype wire

// >>> bench/ufh_host_model.sv
/*
 * Host controller model: issues one request per call and shows line activity.
 * Assumes the bench drives nothing else on these pins and a 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ufh_host_model
    import ufh_pkg::*;
(
    input wire logic clock,
    input wire logic resp_valid,
    input wire logic resp_ack,
    input wire logic resp_stall,
    input wire logic [7:0] resp_data,
    output var logic req_valid,
    output var logic [1:0] req_target,
    output var logic [7:0] req_ep,
    output var logic [2:0] req_alt,
    output var logic [DESC_OFS_W-1:0] req_desc_ofs,
    output var logic bus_activity
);
    initial begin
        req_valid = 1'b0;
        req_target = 2'h0;
        req_ep = 8'h00;
        req_alt = 3'h0;
        req_desc_ofs = 6'h00;
        bus_activity = 1'b0;
    end

    // Answer word: early valid, valid, ack, stall, data byte.
    // Each request carries line activity, which also ends a suspend.
    task automatic request(input logic [1:0] tgt, input logic [7:0] ep, input logic [2:0] alt,
            input logic [DESC_OFS_W-1:0] ofs, output logic [11:0] ans);
        @(negedge clock);
        req_valid = 1'b1;
        req_target = tgt;
        req_ep = ep;
        req_alt = alt;
        req_desc_ofs = ofs;
        bus_activity = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        req_target = ~tgt;
        req_ep = ~ep;
        req_alt = ~alt;
        req_desc_ofs = ~ofs;
        bus_activity = 1'b0;
        ans[11] = resp_valid;
        @(negedge clock);
        ans[10:0] = {resp_valid, resp_ack, resp_stall, resp_data};
    endtask : request
endmodule : ufh_host_model
`default_nettype wire

// >>> bench/tb_usb_fs_hub_hci_device.sv
/*
 * Self-checking bench for the hub/function core: table of boot records and requests.
 * Assumes the host model on the request side and short suspend and resume counts.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_usb_fs_hub_hci_device
    import ufh_pkg::*;
;
    localparam int SUSP = 20;
    localparam int RES = 30;
    localparam logic [DESC_OFS_W-1:0] OFS = 6'h05;
    typedef struct packed {
        logic [3:0] cfg;
        logic [1:0] tgt;
        logic [7:0] ep;
        logic [2:0] alt;
        logic [4:0] mode;
        logic [1:0] resp;
    } ufh_row_t;
    ufh_row_t rows [17] = '{
        '{4'h8, 2'h0, 8'h81, 3'h0, 5'h00, 2'h3}, '{4'h8, 2'h3, 8'h00, 3'h0, 5'h00, 2'h0},
        '{4'h9, 2'h3, 8'h82, 3'h0, 5'h14, 2'h3}, '{4'h9, 2'h3, 8'h83, 3'h0, 5'h14, 2'h2},
        '{4'h9, 2'h3, 8'h03, 3'h2, 5'h14, 2'h3}, '{4'h9, 2'h3, 8'h84, 3'h0, 5'h14, 2'h3},
        '{4'h9, 2'h3, 8'h04, 3'h0, 5'h14, 2'h3}, '{4'h9, 2'h3, 8'h05, 3'h0, 5'h14, 2'h2},
        '{4'h6, 2'h1, 8'h81, 3'h0, 5'h1b, 2'h3}, '{4'h6, 2'h3, 8'h00, 3'h0, 5'h1b, 2'h0},
        '{4'h4, 2'h2, 8'h00, 3'h0, 5'h1a, 2'h3}, '{4'h4, 2'h1, 8'h00, 3'h0, 5'h1a, 2'h0},
        '{4'hf, 2'h0, 8'h82, 3'h0, 5'h1f, 2'h2}, '{4'hf, 2'h2, 8'h03, 3'h1, 5'h1f, 2'h2},
        '{4'h8, 2'h0, 8'h83, 3'h0, 5'h00, 2'h2}, '{4'h8, 2'h0, 8'h04, 3'h0, 5'h00, 2'h3},
        '{4'h4, 2'h2, 8'h82, 3'h0, 5'h1a, 2'h2}
    };
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic cfg_load = 1'b0;
    logic [CFG_W-1:0] cfg_record = 4'h0;
    logic desc_wr = 1'b0;
    logic [DESC_AW-1:0] desc_wr_addr = 8'h00;
    logic [7:0] desc_wr_data = 8'h00;
    logic desc_done = 1'b0;
    logic rwake_en = 1'b0;
    logic wake_req = 1'b0;
    logic [PORTS-1:0] port_susp_set = 3'h0;
    logic [PORTS-1:0] port_susp_clr = 3'h0;
    logic req_valid, bus_activity, attach, hub_mode, hid_emulation_mode, usb_transport;
    logic suspended, resume_drive, resp_valid, resp_ack, resp_stall;
    logic [1:0] req_target;
    logic [7:0] req_ep, resp_data;
    logic [2:0] req_alt;
    logic [DESC_OFS_W-1:0] req_desc_ofs;
    logic [PORTS-1:0] port_connected, port_suspended;
    logic [11:0] ans;
    int errors = 0;
    int checks = 0;

    always #12.5 clock = ~clock;

    ufh_core #(.SUSPEND_CYC(SUSP), .RESUME_CYC(RES)) i_dut (.clock(clock), .rstn(rstn),
        .cfg_load(cfg_load), .cfg_record(cfg_record), .desc_wr(desc_wr),
        .desc_wr_addr(desc_wr_addr), .desc_wr_data(desc_wr_data), .desc_done(desc_done),
        .bus_activity(bus_activity), .req_valid(req_valid), .req_target(req_target),
        .req_ep(req_ep), .req_alt(req_alt), .req_desc_ofs(req_desc_ofs), .rwake_en(rwake_en),
        .wake_req(wake_req), .port_susp_set(port_susp_set), .port_susp_clr(port_susp_clr),
        .attach(attach), .hub_mode(hub_mode), .hid_emulation_mode(hid_emulation_mode),
        .port_connected(port_connected), .port_suspended(port_suspended),
        .usb_transport(usb_transport), .suspended(suspended), .resume_drive(resume_drive),
        .resp_valid(resp_valid), .resp_ack(resp_ack), .resp_stall(resp_stall),
        .resp_data(resp_data));

    ufh_host_model i_host (.clock(clock), .resp_valid(resp_valid), .resp_ack(resp_ack),
        .resp_stall(resp_stall), .resp_data(resp_data), .req_valid(req_valid),
        .req_target(req_target), .req_ep(req_ep), .req_alt(req_alt),
        .req_desc_ofs(req_desc_ofs), .bus_activity(bus_activity));

    function automatic logic [7:0] byte_of(input logic [1:0] tgt);
        return 8'h3c ^ {tgt, OFS};
    endfunction : byte_of

    function automatic logic [11:0] expect_ans(input logic [1:0] tgt, input logic [1:0] r);
        return {1'b0, r[1], r[1] & r[0], r[1] & ~r[0], (r[1] & r[0]) ? byte_of(tgt) : 8'h00};
    endfunction : expect_ans

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic summarize();
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Resets, stores one descriptor byte, loads the record and checks the boot result.
    task automatic boot(input logic [3:0] cfg, input logic [1:0] tgt, input logic [4:0] mode);
        @(negedge clock);
        rstn = 1'b0;
        desc_done = 1'b0;
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        desc_wr = 1'b1;
        desc_wr_addr = {tgt, OFS};
        desc_wr_data = byte_of(tgt);
        @(negedge clock);
        desc_wr = 1'b0;
        cfg_load = 1'b1;
        cfg_record = cfg;
        desc_done = 1'b1;
        @(negedge clock);
        cfg_load = 1'b0;
        chk("attach early", 12'h000, {11'h000, attach});
        @(negedge clock);
        chk("attach", 12'h001, {11'h000, attach});
        chk("mode", {7'h00, mode}, {7'h00, hub_mode, hid_emulation_mode, port_connected});
    endtask : boot

    initial begin
        #50000;
        errors++;
        summarize();
    end

    initial begin
        foreach (rows[i]) begin
            boot(rows[i].cfg, rows[i].tgt, rows[i].mode);
            i_host.request(rows[i].tgt, rows[i].ep, rows[i].alt, OFS, ans);
            chk("answer", expect_ans(rows[i].tgt, rows[i].resp), ans);
        end
        boot(4'h9, 2'h3, 5'h14);
        chk("transport", 12'h000, {11'h000, usb_transport});
        i_host.request(2'h3, 8'h00, 3'h0, OFS, ans);
        chk("transport", 12'h001, {11'h000, usb_transport});
        cfg_load = 1'b1;
        cfg_record = 4'h8;
        @(negedge clock);
        cfg_load = 1'b0;
        port_susp_set = 3'h5;
        @(negedge clock);
        port_susp_set = 3'h0;
        @(negedge clock);
        chk("mode", 12'h014, {7'h00, hub_mode, hid_emulation_mode, port_connected});
        chk("port suspend", 12'h004, {9'h000, port_suspended});
        i_host.request(2'h3, 8'h00, 3'h0, OFS, ans);
        chk("answer", 12'h000, ans);
        port_susp_clr = 3'h4;
        @(negedge clock);
        port_susp_clr = 3'h0;
        i_host.request(2'h3, 8'h00, 3'h0, OFS, ans);
        chk("answer", expect_ans(2'h3, 2'h3), ans);
        repeat (SUSP - 2) @(negedge clock);
        chk("suspended", 12'h000, {11'h000, suspended});
        @(negedge clock);
        chk("suspended", 12'h001, {11'h000, suspended});
        i_host.request(2'h3, 8'h00, 3'h0, OFS, ans);
        chk("answer", 12'h000, ans);
        chk("suspended", 12'h000, {11'h000, suspended});
        repeat (SUSP + 2) @(negedge clock);
        wake_req = 1'b1;
        @(negedge clock);
        chk("wake", 12'h002, {10'h000, suspended, resume_drive});
        rwake_en = 1'b1;
        @(negedge clock);
        wake_req = 1'b0;
        chk("wake", 12'h001, {10'h000, suspended, resume_drive});
        repeat (RES - 1) @(negedge clock);
        chk("wake", 12'h001, {10'h000, suspended, resume_drive});
        @(negedge clock);
        chk("wake", 12'h000, {10'h000, suspended, resume_drive});
        rstn = 1'b0;
        @(negedge clock);
        chk("reset", 12'h000, {2'h0, attach, hub_mode, hid_emulation_mode, port_connected,
            usb_transport, suspended, resume_drive, resp_valid});
        summarize();
    end
endmodule : tb_usb_fs_hub_hci_device
`default_nettype wire
